// >>> hdl/rep_eavesdrop.sv
// module: eavesdrop guard for a multiport repeater, apb registers
// assumes: repeater core feeds one byte stream, dest address first,
// and the expansion match line arrives from other devices asynchronously
// What this block does
// - repeat clean only to ports secure for destination
// - unsecure protected ports get alternating one-zero pattern
// - port valid if dest equals last or preferred
// - per-port mask turns protection off
// - per-port mask spares multicast packets
// - broadcast goes clean to every port
// - optionally pass unmatched when nobody matches
// - repeater match uses own ports plus expansion
`timescale 1ns/1ps
module rep_eavesdrop #(
  parameter int NPORT = rep_pkg::NPORT_DEF,
  parameter int DEPTH = 2
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic [11:0]                 paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        inVld,
  output logic                             inRdy,
  input  wire logic [7:0]                  inData,
  input  wire logic                        inSop,
  input  wire logic                        inEop,
  input  wire logic                        inGood,
  input  wire logic [rep_pkg::PORT_W-1:0]  inPort,
  output logic                             outVld,
  input  wire logic                        outRdy,
  output logic      [NPORT*8-1:0]          outData,
  output logic                             outSop,
  output logic                             outEop,
  input  wire logic                        expMatchIn,
  output logic                             expMatchOut
);
  localparam int AW = rep_pkg::ADDR_W;
  localparam int BW = NPORT * rep_pkg::BYTE_W + 2;
  localparam logic [NPORT-1:0] NONE = '0;
  localparam int PORT_IDX_W = (NPORT > 1) ? $clog2(NPORT) : 1;

  ////////////////////////////////////////////////////////////////////////
  // registers and packet state

  logic [31:0]    ctrl_r;
  logic [NPORT-1:0] protMask_r;
  logic [NPORT-1:0] mcastMask_r;
  logic [NPORT-1:0] passEn_r;
  logic [AW-1:0]  pref_r [NPORT];
  logic [AW-1:0]  last_r [NPORT];
  logic [31:0]    prdata_r;
  logic [AW-1:0]  da_r;
  logic [AW-1:0]  sa_r;
  logic [2:0]     cnt_r;
  logic [2:0]     cnt_nxt;
  logic           daDone_r;
  logic           expMatch_r;
  logic [NPORT-1:0] disruptVec_r;
  logic [NPORT-1:0] disruptVec_nxt;
  logic           expMeta_r;
  logic           expSync_r;
  rep_pkg::rep_phase_e phase_r;
  rep_pkg::rep_phase_e phase_nxt;
  logic [NPORT*AW-1:0] prefFlat;
  logic [NPORT*AW-1:0] lastFlat;
  logic [NPORT-1:0] localMatch;
  logic [NPORT*8-1:0] laneDat;

  rep_strm_if #(.W(BW)) pushIf ();

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  wire logic        setupPh  = psel & ~penable;
  wire logic        accessPh = psel & penable;
  wire logic [11:0] portOff  = paddr - rep_pkg::PORT_BASE;
  wire logic [7:0]  portIdx  = portOff[11:rep_pkg::PORT_SHIFT];
  wire logic [1:0]  portWord = paddr[3:2];
  wire logic        aligned  = (paddr[1:0] == 2'h0);
  wire logic        inPorts  = (paddr >= rep_pkg::PORT_BASE)
                               && (portIdx < 8'(NPORT));
  wire logic        hitCtrl  = aligned && (paddr == rep_pkg::CTRL_OFS);
  wire logic        hitProt  = aligned && (paddr == rep_pkg::PROT_OFS);
  wire logic        hitMcast = aligned && (paddr == rep_pkg::MCAST_OFS);
  wire logic        hitPass  = aligned && (paddr == rep_pkg::PASS_OFS);
  wire logic        hitStat  = aligned && (paddr == rep_pkg::STAT_OFS);
  wire logic        hitPort  = aligned && inPorts;
  wire logic        hitAny   = hitCtrl | hitProt | hitMcast | hitPass
                               | hitStat | hitPort;
  wire logic        wrEn     = accessPh & pwrite;
  wire logic [PORT_IDX_W-1:0] selPort = PORT_IDX_W'(portIdx);

  wire logic [AW-1:0] selPref = hitPort ? pref_r[selPort] : rep_pkg::ADDR_RST;
  wire logic [AW-1:0] selLast = hitPort ? last_r[selPort] : rep_pkg::ADDR_RST;
  wire logic [31:0]   zeroPad = 32'h0;

  wire logic [31:0] statWord = zeroPad
    | 32'(disruptVec_r)
    | (32'(expMatch_r) << rep_pkg::STAT_EXP)
    | (32'(localMatch) << rep_pkg::STAT_LOCAL);

  wire logic [31:0] portWordVal =
      (portWord == rep_pkg::PREF_LO) ? selPref[31:0]
    : (portWord == rep_pkg::PREF_HI) ? {16'h0, selPref[AW-1:32]}
    : (portWord == rep_pkg::LAST_LO) ? selLast[31:0]
    : {16'h0, selLast[AW-1:32]};

  wire logic [31:0] rdWord =
      hitCtrl  ? ctrl_r
    : hitProt  ? 32'(protMask_r)
    : hitMcast ? 32'(mcastMask_r)
    : hitPass  ? 32'(passEn_r)
    : hitStat  ? statWord
    : hitPort  ? portWordVal
    : zeroPad;

  // zero-wait slave: read data is caught in setup, answered in access
  assign pready  = 1'b1;
  assign pslverr = accessPh & ~hitAny;
  assign prdata  = prdata_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= rep_pkg::REG_RST;
    end else if (setupPh) begin
      prdata_r <= pwrite ? rep_pkg::REG_RST : rdWord;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r      <= rep_pkg::REG_RST;
      protMask_r  <= NONE;
      mcastMask_r <= NONE;
      passEn_r    <= NONE;
    end else if (wrEn) begin
      if (hitCtrl) ctrl_r <= pwdata;
      if (hitProt) protMask_r <= pwdata[NPORT-1:0];
      if (hitMcast) mcastMask_r <= pwdata[NPORT-1:0];
      if (hitPass) passEn_r <= pwdata[NPORT-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // packet walk: dest bytes, source bytes, then payload

  wire logic acc = inVld & inRdy;
  rep_pkg::rep_phase_e curPhase;
  assign curPhase = inSop ? rep_pkg::PH_DA : phase_r;
  wire logic [2:0] curCnt  = inSop ? rep_pkg::FIELD_FIRST : cnt_r;
  wire logic       fldEnd  = (curCnt == rep_pkg::FIELD_LAST);
  wire logic       daByte  = acc && (curPhase == rep_pkg::PH_DA);
  wire logic       saByte  = acc && (curPhase == rep_pkg::PH_SA);
  wire logic       decide  = saByte && fldEnd;
  wire logic       inData_ = acc && (curPhase == rep_pkg::PH_DATA);
  wire logic [5:0] bytePos = {curCnt, 3'b000};
  wire logic       lastWe  = inData_ && inEop && inGood
                             && (inPort < rep_pkg::PORT_W'(NPORT));

  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt   = cnt_r;
    if (acc) begin
      phase_nxt = curPhase;
      cnt_nxt   = curCnt + 3'h1;
      if (fldEnd) begin
        cnt_nxt = rep_pkg::FIELD_FIRST;
        unique case (curPhase)
          rep_pkg::PH_DA:   phase_nxt = rep_pkg::PH_SA;
          rep_pkg::PH_SA:   phase_nxt = rep_pkg::PH_DATA;
          rep_pkg::PH_DATA: phase_nxt = rep_pkg::PH_DATA;
          rep_pkg::PH_IDLE: phase_nxt = rep_pkg::PH_IDLE;
        endcase
      end
      if (inEop) phase_nxt = rep_pkg::PH_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r  <= rep_pkg::PH_IDLE;
      cnt_r    <= rep_pkg::FIELD_FIRST;
      daDone_r <= 1'b0;
    end else begin
      phase_r  <= phase_nxt;
      cnt_r    <= cnt_nxt;
      daDone_r <= daByte && fldEnd;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      da_r <= rep_pkg::ADDR_RST;
      sa_r <= rep_pkg::ADDR_RST;
    end else begin
      if (daByte) da_r[bytePos +: 8] <= inData;
      if (saByte) sa_r[bytePos +: 8] <= inData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-port address store

  for (genvar p = 0; p < NPORT; p++) begin : g_store
    wire logic hereW = wrEn && hitPort && (selPort == PORT_IDX_W'(p));
    wire logic hereL = lastWe && (inPort == rep_pkg::PORT_W'(p));
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pref_r[p] <= rep_pkg::ADDR_RST;
        last_r[p] <= rep_pkg::ADDR_RST;
      end else begin
        if (hereW && portWord == rep_pkg::PREF_LO) pref_r[p][31:0] <= pwdata;
        if (hereW && portWord == rep_pkg::PREF_HI) begin
          pref_r[p][AW-1:32] <= pwdata[15:0];
        end
        // only a good frame teaches where a station lives
        if (hereL) last_r[p] <= sa_r;
      end
    end
    assign prefFlat[p*AW +: AW] = pref_r[p];
    assign lastFlat[p*AW +: AW] = last_r[p];
  end

  rep_addr_match #(.NPORT(NPORT)) u_match (
    .dstAddr   (da_r),
    .prefFlat  (prefFlat),
    .lastFlat  (lastFlat),
    .portMatch (localMatch)
  );

  ////////////////////////////////////////////////////////////////////////
  // decision

  // the first stage only feeds the second: expansion line is asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      expMeta_r <= 1'b0;
      expSync_r <= 1'b0;
    end else begin
      expMeta_r <= expMatchIn;
      expSync_r <= expMeta_r;
    end
  end

  wire logic protEn  = ctrl_r[rep_pkg::CTRL_EN_BIT];
  wire logic isBcast = (da_r == rep_pkg::BCAST_ADDR);
  wire logic isMcast = da_r[rep_pkg::MCAST_BIT];
  wire logic anyHit  = (|localMatch) | expSync_r;

  // the whole source field is the settling time for the other devices
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      expMatch_r <= 1'b0;
    end else if (acc && (inEop || inSop)) begin
      expMatch_r <= 1'b0;
    end else if (daDone_r) begin
      expMatch_r <= (|localMatch) & ~isBcast;
    end
  end
  assign expMatchOut = expMatch_r;

  for (genvar p = 0; p < NPORT; p++) begin : g_decide
    wire logic mcSpare = isMcast & mcastMask_r[p];
    wire logic passOk  = passEn_r[p] & ~anyHit;
    assign disruptVec_nxt[p] = protEn & ~isBcast
      & ~localMatch[p]
      & ~protMask_r[p]
      & ~mcSpare & ~passOk;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      disruptVec_r <= NONE;
    end else if (acc && inSop) begin
      disruptVec_r <= NONE;
    end else if (decide) begin
      disruptVec_r <= disruptVec_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output lanes: address fields always clean, payload may be replaced

  for (genvar p = 0; p < NPORT; p++) begin : g_lane
    wire logic jam = inData_ && disruptVec_r[p];
    assign laneDat[p*8 +: 8] = jam ? rep_pkg::DISRUPT_PAT : inData;
  end

  assign pushIf.vld = inVld;
  assign pushIf.dat = {inSop, inEop, laneDat};
  assign inRdy      = pushIf.rdy;

  logic [BW-1:0] bufDat;

  rep_skid_buf #(.W(BW), .DEPTH(DEPTH)) u_buf (
    .clk    (clk),
    .rst_b  (rst_b),
    .push   (pushIf),
    .outVld (outVld),
    .outRdy (outRdy),
    .outDat (bufDat)
  );

  assign outSop  = bufDat[BW-1];
  assign outEop  = bufDat[BW-2];
  assign outData = bufDat[NPORT*8-1:0];

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_decide;
    decide;
  endsequence
  sequence s_jam_byte0;
    inData_ && disruptVec_r[0];
  endsequence
  a_secure_clean: assert property (s_decide |=>
    (disruptVec_r & $past(localMatch)) == NONE)
    else $error("matching port was marked for disruption");
  a_jam_pattern: assert property (s_jam_byte0 |->
    pushIf.dat[7:0] == rep_pkg::DISRUPT_PAT)
    else $error("disrupted lane does not carry the pattern");
  a_plain_unsecure: assert property (decide && protEn && !isBcast
    && protMask_r == NONE && mcastMask_r == NONE && passEn_r == NONE
    |=> disruptVec_r == ~$past(localMatch))
    else $error("unprotected choice wrong for unmatched ports");
  a_two_addr: assert property (decide
    && (da_r == pref_r[0] || da_r == last_r[0]) |=> !disruptVec_r[0])
    else $error("port 0 address hit ignored");
  a_prot_mask: assert property (s_decide |=>
    (disruptVec_r & $past(protMask_r)) == NONE)
    else $error("masked port disrupted");
  a_mcast_mask: assert property (decide && isMcast |=>
    (disruptVec_r & $past(mcastMask_r)) == NONE)
    else $error("multicast spared port disrupted");
  a_bcast_clean: assert property (decide && isBcast |=>
    (disruptVec_r == NONE)[*2])
    else $error("broadcast disrupted");
  a_pass_alone: assert property (decide && !anyHit |=>
    (disruptVec_r & $past(passEn_r)) == NONE)
    else $error("pass-through port disrupted with no match anywhere");
  a_exp_drive: assert property (daDone_r |=>
    expMatchOut == ($past(|localMatch) && !$past(isBcast)))
    else $error("expansion match output wrong");
  a_exp_listen: assert property (decide && expSync_r && protEn
    && !isBcast && !isMcast |=> (disruptVec_r & $past(passEn_r))
    == ($past(passEn_r) & ~$past(protMask_r) & ~$past(localMatch)))
    else $error("remote match not honoured");
  a_last_learn: assert property (lastWe |=>
    last_r[$past(inPort)] == $past(sa_r))
    else $error("last source address not learned");
  a_mcast_class: assert property (decide && isMcast && !isBcast
    && mcastMask_r == {NPORT{1'b1}} |=> disruptVec_r == NONE)
    else $error("first-bit-one destination not treated as multicast");
endmodule

// >>> hdl/rep_pkg.sv
// package: constants, register map and state type of the eavesdrop guard
// assumes: 32-bit apb, byte-wide packet stream, lsb of each byte sent first
package rep_pkg;
  localparam int          ADDR_W      = 48;
  localparam int          BYTE_W      = 8;
  localparam int          NPORT_DEF   = 5;
  localparam int          PORT_W      = 3;
  localparam logic [2:0]  FIELD_FIRST = 3'h0;
  localparam logic [2:0]  FIELD_LAST  = 3'h5;
  localparam logic [7:0]  DISRUPT_PAT = 8'h55;
  localparam logic [47:0] BCAST_ADDR  = 48'hFFFFFFFFFFFF;
  localparam int          MCAST_BIT   = 0;
  localparam int          CTRL_EN_BIT = 0;
  localparam int          STAT_EXP    = 8;
  localparam int          STAT_LOCAL  = 16;
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] PROT_OFS    = 12'h004;
  localparam logic [11:0] MCAST_OFS   = 12'h008;
  localparam logic [11:0] PASS_OFS    = 12'h00C;
  localparam logic [11:0] STAT_OFS    = 12'h010;
  localparam logic [11:0] PORT_BASE   = 12'h040;
  localparam int          PORT_SHIFT  = 4;
  localparam logic [1:0]  PREF_LO     = 2'h0;
  localparam logic [1:0]  PREF_HI     = 2'h1;
  localparam logic [1:0]  LAST_LO     = 2'h2;
  localparam logic [1:0]  LAST_HI     = 2'h3;
  localparam logic [31:0] REG_RST     = 32'h0;
  localparam logic [47:0] ADDR_RST    = 48'h0;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_DA   = 2'b01,
    PH_SA   = 2'b11,
    PH_DATA = 2'b10
  } rep_phase_e;
endpackage

// >>> hdl/rep_strm_if.sv
// interface: valid/ready word stream between guard and its output buffer
// assumes: one clock, word taken when vld and rdy are both high
`timescale 1ns/1ps
interface rep_strm_if #(parameter int W = 8) ();
  logic         vld;
  logic         rdy;
  logic [W-1:0] dat;
  modport src (output vld, output dat, input rdy);
  modport snk (input vld, input dat, output rdy);
endinterface

// >>> hdl/rep_addr_match.sv
// module: per-port compare of a destination against two stored addresses
// assumes: addresses packed flat, port p in bits [p*48 +: 48]
`timescale 1ns/1ps
module rep_addr_match #(
  parameter int NPORT = rep_pkg::NPORT_DEF
) (
  input  wire logic [rep_pkg::ADDR_W-1:0]       dstAddr,
  input  wire logic [NPORT*rep_pkg::ADDR_W-1:0] prefFlat,
  input  wire logic [NPORT*rep_pkg::ADDR_W-1:0] lastFlat,
  output logic      [NPORT-1:0]                 portMatch
);
  localparam int AW = rep_pkg::ADDR_W;

  // pure compare, no state: the caller decides when the result counts
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    wire logic prefHit = (prefFlat[p*AW +: AW] == dstAddr);
    wire logic lastHit = (lastFlat[p*AW +: AW] == dstAddr);
    assign portMatch[p] = prefHit | lastHit;
  end
endmodule

// >>> hdl/rep_skid_buf.sv
// module: small fifo holding per-port output words
// assumes: drain side may stall at will; push side honours rdy
`timescale 1ns/1ps
module rep_skid_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  rep_strm_if.snk           push,
  output logic              outVld,
  input  wire logic         outRdy,
  output logic [W-1:0]      outDat
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0]   count_r;

  wire logic doPush = push.vld & push.rdy;
  wire logic doPop  = outVld & outRdy;

  // ready is honest: a stalled drain backs up into the guard's input
  assign push.rdy = (count_r != FULL_CNT);
  assign outVld   = (count_r != '0);
  assign outDat   = mem_r[rdPtr_r];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] ptr);
    bump = (ptr == PW'(DEPTH - 1)) ? '0 : ptr + 1'b1;
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) wrPtr_r <= bump(wrPtr_r);
      if (doPop) rdPtr_r <= bump(rdPtr_r);
      count_r <= count_r + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end

  always_ff @(posedge clk) begin
    if (doPush) mem_r[wrPtr_r] <= push.dat;
  end
endmodule

// >>> test/rep_sink_model.sv
// partner: drain side of the guard output, stalls at random
// assumes: guard samples outRdy at the rising edge of clk
`timescale 1ns/1ps
module rep_sink_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic hold,
  output logic      outRdy
);
  // random stalls; hold keeps it low so the buffer must fill and refuse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outRdy <= 1'b0;
    end else begin
      outRdy <= !hold && (($urandom % 4) != 0);
    end
  end
endmodule

// >>> test/repeater_eavesdrop_protection_tb.sv
// testbench: guard driven over apb and byte stream, outputs scored from a queue
// assumes: rep_eavesdrop with default parameters, rep_sink_model on the drain
`timescale 1ns/1ps
module repeater_eavesdrop_protection_tb;
  localparam int NP = rep_pkg::NPORT_DEF;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, inVld = 1'b0, inRdy, inSop = 1'b0, inEop = 1'b0;
  logic inGood = 1'b0, outVld, outRdy, outSop, outEop, expIn = 1'b0, hold = 1'b0, e, expOut;
  logic [7:0] inData = 8'h0;
  logic [2:0] inPort = 3'h0;
  logic [NP*8-1:0] outData;
  logic en = 1'b0;
  logic [NP-1:0] prot = '0, mc = '0, pass = '0;
  logic [47:0] pref[NP], last[NP], d, s;
  logic [NP*8+1:0] expQ[$], x;
  int miscompares = 0, checks = 0;

  always #5 clk = ~clk;

  rep_eavesdrop dut (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .inVld(inVld), .inRdy(inRdy),
    .inData(inData), .inSop(inSop), .inEop(inEop), .inGood(inGood),
    .inPort(inPort), .outVld(outVld), .outRdy(outRdy), .outData(outData),
    .outSop(outSop), .outEop(outEop), .expMatchIn(expIn), .expMatchOut(expOut));
  rep_sink_model sink (.clk(clk), .rst_b(rst_b), .hold(hold), .outRdy(outRdy));

  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [63:0] seen, input logic [63:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer; an edge passes first so psel is never set twice in a step
  task apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] xd, input logic xe);
    apb(a, 1'b0, 32'h0);
    check(64'(r), 64'(xd), "read data");
    check(64'(e), 64'(xe), "read error flag");
  endtask

  function automatic logic [11:0] pa(input int p, input logic [1:0] k);
    return rep_pkg::PORT_BASE + 12'(p << rep_pkg::PORT_SHIFT) + 12'({k, 2'b00});
  endfunction

  function automatic logic [47:0] rnd48();
    logic [47:0] v;
    v = 48'({$urandom, $urandom});
    v[0] = 1'b0;
    return v;
  endfunction

  // any local port holding the destination, from the programmed state
  function automatic logic hit_any(input logic [47:0] a);
    hit_any = 1'b0;
    for (int p = 0; p < NP; p++) hit_any |= (a == pref[p]) || (a == last[p]);
  endfunction

  // reference decision per port, worked out from the programmed state
  function automatic logic [NP-1:0] dis_vec(input logic [47:0] a);
    logic [NP-1:0] m, v;
    for (int p = 0; p < NP; p++) m[p] = (a == pref[p]) || (a == last[p]);
    for (int p = 0; p < NP; p++)
      v[p] = en && (a != rep_pkg::BCAST_ADDR)
             && !prot[p] && !(a[0] && mc[p]) && !m[p]
             && !(pass[p] && m == '0 && !expIn);
    return v;
  endfunction

  // caller is just after an edge; the expected word is queued once the byte is taken
  task send(input logic [7:0] b, input logic so, input logic eo, input logic [NP-1:0] dv);
    logic [NP*8-1:0] w;
    inVld <= 1'b1; inData <= b; inSop <= so; inEop <= eo;
    do @(posedge clk); while (inRdy !== 1'b1);
    for (int p = 0; p < NP; p++) w[p*8+:8] = dv[p] ? rep_pkg::DISRUPT_PAT : b;
    expQ.push_back({so, eo, w});
  endtask

  task frame(input logic [47:0] da, input logic [47:0] sa, input int n, input logic g,
             input logic [2:0] pt);
    logic [NP-1:0] dv;
    @(posedge clk);
    dv = dis_vec(da);
    inGood <= g; inPort <= pt;
    for (int k = 0; k < 6; k++) send(da[8*k+:8], k == 0, 1'b0, '0);
    for (int k = 0; k < 6; k++) send(sa[8*k+:8], 1'b0, 1'b0, '0);
    check(64'(expOut), 64'(hit_any(da) && da != rep_pkg::BCAST_ADDR),
          "expansion match out");
    for (int k = 0; k < n; k++) send(8'($urandom), 1'b0, k == n - 1, dv);
    inVld <= 1'b0;
    if (g && n > 0) last[pt] = sa;
    repeat (4) @(posedge clk);
  endtask

  task tdone(input string t);
    $display("test %s done", t);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rst_b && outVld === 1'b1 && outRdy === 1'b1) begin
      x = (expQ.size() > 0) ? expQ.pop_front() : '1;
      check(64'({outSop, outEop, outData}), 64'(x), "output word");
    end
  end

  initial begin
    #200us;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    void'($urandom(32'hED3D2A37));
    for (int p = 0; p < NP; p++) last[p] = rep_pkg::ADDR_RST;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(rep_pkg::CTRL_OFS, rep_pkg::REG_RST, 1'b0);
    rd(rep_pkg::PASS_OFS, rep_pkg::REG_RST, 1'b0);
    rd(pa(4, rep_pkg::LAST_LO), rep_pkg::REG_RST, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    tdone("reset and unmapped");
    for (int p = 0; p < NP; p++) begin
      pref[p] = rnd48();
      apb(pa(p, rep_pkg::PREF_LO), 1'b1, pref[p][31:0]);
      apb(pa(p, rep_pkg::PREF_HI), 1'b1, {16'h0, pref[p][47:32]});
      rd(pa(p, rep_pkg::PREF_HI), {16'h0, pref[p][47:32]}, 1'b0);
    end
    en = 1'b1;
    apb(rep_pkg::CTRL_OFS, 1'b1, 32'h1);
    frame(pref[2], rnd48(), 3, 1'b0, 3'h0);
    frame(rep_pkg::BCAST_ADDR, rnd48(), 2, 1'b0, 3'h1);
    mc = 5'h05;
    apb(rep_pkg::MCAST_OFS, 1'b1, 32'(mc));
    frame(rnd48() | 48'h1, rnd48(), 2, 1'b0, 3'h1);
    prot = 5'h02;
    apb(rep_pkg::PROT_OFS, 1'b1, 32'(prot));
    frame(rnd48(), rnd48(), 2, 1'b0, 3'h0);
    tdone("unicast broadcast multicast mask");
    s = rnd48();
    frame(rnd48(), s, 1, 1'b1, 3'h3);
    rd(pa(3, rep_pkg::LAST_LO), s[31:0], 1'b0);
    frame(s, rnd48(), 2, 1'b0, 3'h0);
    frame(rnd48(), rnd48(), 2, 1'b0, 3'h1);
    tdone("source learning");
    pass = 5'h18;
    apb(rep_pkg::PASS_OFS, 1'b1, 32'(pass));
    frame(rnd48(), rnd48(), 2, 1'b0, 3'h0);
    expIn <= 1'b1;
    frame(rnd48(), rnd48(), 2, 1'b0, 3'h0);
    expIn <= 1'b0;
    mc = '1;
    apb(rep_pkg::MCAST_OFS, 1'b1, 32'(mc));
    frame(rnd48() | 48'h1, rnd48(), 2, 1'b0, 3'h4);
    tdone("pass unmatched and expansion");
    hold <= 1'b1;
    fork
      begin
        repeat (30) @(posedge clk);
        hold <= 1'b0;
      end
    join_none
    frame(pref[0], rnd48(), 8, 1'b1, 3'h2);
    tdone("buffer full");
    for (int i = 0; i < 8; i++) begin
      prot = NP'($urandom); mc = NP'($urandom); pass = NP'($urandom);
      apb(rep_pkg::PROT_OFS, 1'b1, 32'(prot));
      apb(rep_pkg::MCAST_OFS, 1'b1, 32'(mc));
      apb(rep_pkg::PASS_OFS, 1'b1, 32'(pass));
      case ($urandom % 4)
        0: d = pref[$urandom % NP];
        1: d = rep_pkg::BCAST_ADDR;
        2: d = rnd48() | 48'h1;
        default: d = last[$urandom % NP];
      endcase
      frame(d, rnd48(), 1 + $urandom % 4, 1'($urandom), 3'($urandom % NP));
    end
    tdone("random frames");
    for (int i = 0; i < 300 && expQ.size() > 0; i++) @(posedge clk);
    check(64'(expQ.size()), 64'h0, "words left undelivered");
    complete_run();
  end
endmodule
